// >>> shared/sci_irq_dma_map.vh
/*
 Register page, offsets, field positions, reset values and source codes
 of the serial port interrupt and DMA request logic.
 Assumes inclusion by bare name from the design file only.
*/
`ifndef SCI_IRQ_DMA_MAP_VH
`define SCI_IRQ_DMA_MAP_VH

// Register pages of the two instances
`define PAGE_INST0      8'h18
`define PAGE_INST1      8'h19

// Offsets inside the page
`define OFS_RX_CNT_PTR  8'hF0
`define OFS_RX_ADR_PTR  8'hF1
`define OFS_TX_CNT_PTR  8'hF2
`define OFS_TX_ADR_PTR  8'hF3
`define OFS_IRQ_VECTOR  8'hF4
`define OFS_MATCH_CHAR  8'hF5
`define OFS_IRQ_MASK    8'hF6
`define OFS_IRQ_FLAGS   8'hF7
`define OFS_HOLDING     8'hF8
`define OFS_PRIORITY    8'hF9
`define OFS_MISC_FIRST  8'hFA
`define OFS_CHAR_FMT    8'hFA
`define OFS_CLOCK_SET   8'hFB
`define OFS_BAUD_HIGH   8'hFC
`define OFS_BAUD_LOW    8'hFD
`define OFS_SYNC_IN     8'hFE
`define OFS_SYNC_OUT    8'hFF
`define MISC_COUNT      6

// irq_mask fields
`define MSK_TX_SRC_SEL  7
`define MSK_RX_DONE     6
`define MSK_TX_DONE     5
`define MSK_RXE         4
`define MSK_RXA         3
`define MSK_RXB         2
`define MSK_RXDI        1
`define MSK_TXDI        0

// irq_flags fields
`define FLG_OE          7
`define FLG_FE          6
`define FLG_PE          5
`define FLG_RXAP        4
`define FLG_RXBP        3
`define FLG_RXDP        2
`define FLG_TXBEM       1
`define FLG_TX_SHIFT_EMPTY 0

// irq_dma_priority fields
`define PRI_RX_DMA_EN   7
`define PRI_TX_DMA_EN   6
`define PRI_SEARCH_EN   5

// Encoded source bits
`define EV_RX_ERROR     2'h0
`define EV_BRK_ADDR     2'h1
`define EV_RX_DATA      2'h2
`define EV_TX_EMPTY     2'h3

`define REG_RESET       8'h00

`endif

// >>> verilog/serial_irq_dma.v
/*
 Interrupt and DMA request logic of a multiprotocol serial port:
 register page, status flags, vector encoding, two DMA channels.
 Assumes a serial core that pulses character and empty events, a
 core register port with one-cycle strobes, and a DMA controller
 that acknowledges each request with a one-cycle pulse.
*/
//
// Overview of operation
// - Raise receiver data, error, address, break interrupts
// - Buffer-select bit picks transmit empty source
// - Four levels encoded into two vector bits
// - Priority: rx DMA, tx DMA, rx irq, tx irq
// - Codes 110 tx, 100 rx, 010 break, 000 error
// - Shared vector; software polls, clears flags
// - Separate receive and transmit DMA channels
// - Receive DMA starts on received character
// - Transmit DMA starts on buffer write
// - DMA replaces data and shift-empty sources
// - Last byte sets end-of-block flag, interrupt
// - Receive error stops receive DMA
// - Clearing error, reading buffer resumes DMA
// - Matched character skipped; DMA continues after
// - Registers at F0h-FFh; F8h split buffers
// - Instances in pages 18h and 19h
// - Rx counter pointer: location, destination select
// - Rx address pointer: location, segment select
// - Tx counter pointer: location, source select
// - Tx address pointer: location, segment select
// - Encoded vector bits read-only, set by hardware
// - Status flags clear-only, individually
`include "sci_irq_dma_map.vh"
`timescale 1ns/100ps
`default_nettype none

module serial_irq_dma #(
	parameter [7:0] INST_PAGE = `PAGE_INST0
) (
	// Clock and reset
	input  wire       clk_i,
	input  wire       sys_rst_i,
	// Core register port
	input  wire [7:0] reg_page_i,
	input  wire [7:0] reg_addr_i,
	input  wire       reg_wr_i,
	input  wire       reg_rd_i,
	input  wire [7:0] reg_wdata_i,
	output reg  [7:0] reg_rdata_o,
	// Serial receiver events
	input  wire       rx_char_i,
	input  wire [7:0] rx_data_i,
	input  wire       rx_frame_err_i,
	input  wire       rx_parity_err_i,
	input  wire       rx_char_match_i,
	input  wire       rx_addr_match_i,
	input  wire       rx_break_i,
	// Serial transmitter
	input  wire       tx_buf_empty_i,
	input  wire       tx_shift_empty_i,
	output reg        tx_load_o,
	output reg  [7:0] tx_data_o,
	// DMA controller
	input  wire       dma_rx_ack_i,
	input  wire       dma_rx_last_i,
	input  wire       dma_tx_ack_i,
	input  wire       dma_tx_last_i,
	input  wire [7:0] dma_tx_data_i,
	output reg        dma_rx_req_o,
	output reg        dma_tx_req_o,
	output reg  [7:0] rx_data_o,
	output reg  [7:0] rx_cnt_ptr_o,
	output reg  [7:0] rx_adr_ptr_o,
	output reg  [7:0] tx_cnt_ptr_o,
	output reg  [7:0] tx_adr_ptr_o,
	// Processor interrupt
	output reg        irq_o,
	output reg  [7:0] irq_vector_o
);

////////////////////////////////////////////////////////////////////////
// Page and offset compare shared by every write decode and the holding read strobe
function sel;
	input [7:0] page;
	input [7:0] addr;
	input [7:0] ofs;
	begin
		sel = (page == INST_PAGE) && (addr == ofs);
	end
endfunction

wire wr_rcp = reg_wr_i & sel(reg_page_i, reg_addr_i, `OFS_RX_CNT_PTR);
wire wr_rap = reg_wr_i & sel(reg_page_i, reg_addr_i, `OFS_RX_ADR_PTR);
wire wr_tcp = reg_wr_i & sel(reg_page_i, reg_addr_i, `OFS_TX_CNT_PTR);
wire wr_tap = reg_wr_i & sel(reg_page_i, reg_addr_i, `OFS_TX_ADR_PTR);
wire wr_vec = reg_wr_i & sel(reg_page_i, reg_addr_i, `OFS_IRQ_VECTOR);
wire wr_mch = reg_wr_i & sel(reg_page_i, reg_addr_i, `OFS_MATCH_CHAR);
wire wr_msk = reg_wr_i & sel(reg_page_i, reg_addr_i, `OFS_IRQ_MASK);
wire wr_flg = reg_wr_i & sel(reg_page_i, reg_addr_i, `OFS_IRQ_FLAGS);
wire wr_txh = reg_wr_i & sel(reg_page_i, reg_addr_i, `OFS_HOLDING);
wire wr_pri = reg_wr_i & sel(reg_page_i, reg_addr_i, `OFS_PRIORITY);
wire rd_rxh = reg_rd_i & sel(reg_page_i, reg_addr_i, `OFS_HOLDING);

////////////////////////////////////////////////////////////////////////
// Register state; pointer registers are the outputs themselves,
// so the DMA controller sees a write on the very next edge
reg  [4:0] vec_base_r;
reg  [1:0] ev_r;
reg  [7:0] match_char_r;
reg  [7:0] mask_r;
reg  [7:0] mask_nxt;
reg  [7:0] flags_r;
reg  [7:0] flags_nxt;
reg  [7:0] pri_r;
reg  [7:0] pri_nxt;
reg  [7:0] misc_r [0:`MISC_COUNT-1];
reg        rx_full_r;
reg        rx_skip_r;
reg        tx_run_r;
reg        tx_want_r;

wire rx_dma_en = pri_r[`PRI_RX_DMA_EN];
wire tx_dma_en = pri_r[`PRI_TX_DMA_EN];
wire search_en = pri_r[`PRI_SEARCH_EN];
wire tx_empty_source_sel = mask_r[`MSK_TX_SRC_SEL];
wire rx_err    = flags_r[`FLG_OE] | flags_r[`FLG_FE] | flags_r[`FLG_PE];
wire rx_stall  = rx_dma_en & rx_err;
wire overrun   = rx_char_i & rx_full_r;
wire skip_char = rx_char_i & search_en & rx_char_match_i & rx_dma_en;
wire rx_done   = dma_rx_ack_i & dma_rx_last_i;
wire tx_done   = dma_tx_ack_i & dma_tx_last_i;
wire tx_evt    = tx_empty_source_sel ? tx_buf_empty_i : tx_shift_empty_i;

// Receive raise may happen only with nothing outstanding on the channel
// A stalled or skipped byte waits in the holding register meanwhile
wire rx_raise  = rx_dma_en & rx_full_r & ~rx_skip_r & ~rx_stall
	& ~dma_rx_req_o;
wire tx_raise  = tx_want_r & ~dma_tx_req_o & ~rx_raise;

////////////////////////////////////////////////////////////////////////
// Status flags: a write clears only the bits written as zero, and
// a hardware event in the same cycle still wins
always @* begin
	flags_nxt = flags_r;
	if (wr_flg)
		flags_nxt = flags_r & reg_wdata_i;
	if (overrun)
		flags_nxt[`FLG_OE] = 1'b1;
	if (rx_char_i & rx_frame_err_i)
		flags_nxt[`FLG_FE] = 1'b1;
	if (rx_char_i & rx_parity_err_i)
		flags_nxt[`FLG_PE] = 1'b1;
	if (rx_addr_match_i | skip_char)
		flags_nxt[`FLG_RXAP] = 1'b1;
	if (rx_break_i)
		flags_nxt[`FLG_RXBP] = 1'b1;
	if (rx_char_i & ~rx_dma_en)
		flags_nxt[`FLG_RXDP] = 1'b1;
	if (tx_buf_empty_i)
		flags_nxt[`FLG_TXBEM] = 1'b1;
	if (tx_shift_empty_i)
		flags_nxt[`FLG_TX_SHIFT_EMPTY] = 1'b1;
end

always @* begin
	mask_nxt = mask_r;
	if (wr_msk) begin
		// End-of-block bits accept only a clear; a block ending in
		// the same cycle still sets them, so no end is ever lost
		mask_nxt = reg_wdata_i;
		mask_nxt[`MSK_RX_DONE] = mask_r[`MSK_RX_DONE] & reg_wdata_i[`MSK_RX_DONE];
		mask_nxt[`MSK_TX_DONE] = mask_r[`MSK_TX_DONE] & reg_wdata_i[`MSK_TX_DONE];
	end
	if (rx_done)
		mask_nxt[`MSK_RX_DONE] = 1'b1;
	if (tx_done)
		mask_nxt[`MSK_TX_DONE] = 1'b1;
end

// Enables drop at end of block, so chaining needs a fresh set
// A software write in the same cycle is taken as the newer intent
always @* begin
	pri_nxt = pri_r;
	if (rx_done)
		pri_nxt[`PRI_RX_DMA_EN] = 1'b0;
	if (tx_done)
		pri_nxt[`PRI_TX_DMA_EN] = 1'b0;
	if (wr_pri)
		pri_nxt = reg_wdata_i;
end

////////////////////////////////////////////////////////////////////////
// Interrupt sources and encoding
wire src_err = rx_err & mask_r[`MSK_RXE];
wire src_brk = (flags_r[`FLG_RXAP] & mask_r[`MSK_RXA])
	| (flags_r[`FLG_RXBP] & mask_r[`MSK_RXB]);
// Data pending is never set while receive DMA runs, so the
// end-of-block bit is then the only receive data source
wire src_rx  = (flags_r[`FLG_RXDP] | mask_r[`MSK_RX_DONE])
	& mask_r[`MSK_RXDI];
// Shift-empty stays flagged during transmit DMA but is kept off
// the interrupt, as each such event only paces the next request
wire src_tx  = (mask_r[`MSK_TX_DONE]
	| (tx_empty_source_sel ? flags_r[`FLG_TXBEM]
	: flags_r[`FLG_TX_SHIFT_EMPTY] & ~tx_dma_en))
	& mask_r[`MSK_TXDI];
wire src_any = src_err | src_brk | src_rx | src_tx;

// With no source left the last code is kept for a late vector read
reg [1:0] ev_nxt;
always @* begin
	// Receive sources outrank transmit
	if (src_err)
		ev_nxt = `EV_RX_ERROR;
	else if (src_brk)
		ev_nxt = `EV_BRK_ADDR;
	else if (src_rx)
		ev_nxt = `EV_RX_DATA;
	else if (src_tx)
		ev_nxt = `EV_TX_EMPTY;
	else
		ev_nxt = ev_r;
end

////////////////////////////////////////////////////////////////////////
// Read data, registered one cycle after the strobe
// Page compare folded in here, so a foreign page reads as zero
reg [7:0] rdata_nxt;
always @* begin
	rdata_nxt = `REG_RESET;
	if (reg_page_i == INST_PAGE) begin
		case (reg_addr_i)
		`OFS_RX_CNT_PTR: rdata_nxt = rx_cnt_ptr_o;
		`OFS_RX_ADR_PTR: rdata_nxt = rx_adr_ptr_o;
		`OFS_TX_CNT_PTR: rdata_nxt = tx_cnt_ptr_o;
		`OFS_TX_ADR_PTR: rdata_nxt = tx_adr_ptr_o;
		`OFS_IRQ_VECTOR: rdata_nxt = irq_vector_o;
		`OFS_MATCH_CHAR: rdata_nxt = match_char_r;
		`OFS_IRQ_MASK:   rdata_nxt = mask_r;
		`OFS_IRQ_FLAGS:  rdata_nxt = flags_r;
		`OFS_HOLDING:    rdata_nxt = rx_data_o;
		`OFS_PRIORITY:   rdata_nxt = pri_r;
		`OFS_CHAR_FMT:   rdata_nxt = misc_r[0];
		`OFS_CLOCK_SET:  rdata_nxt = misc_r[1];
		`OFS_BAUD_HIGH:  rdata_nxt = misc_r[2];
		`OFS_BAUD_LOW:   rdata_nxt = misc_r[3];
		`OFS_SYNC_IN:    rdata_nxt = misc_r[4];
		`OFS_SYNC_OUT:   rdata_nxt = misc_r[5];
		default:         rdata_nxt = `REG_RESET;
		endcase
	end
end

////////////////////////////////////////////////////////////////////////
// Serial setup registers, stored for the framing side
// Contents are not used inside this block, only read back
genvar gi;
generate
	for (gi = 0; gi < `MISC_COUNT; gi = gi + 1) begin : g_misc
		// Offset worked out at full width, only its low byte decodes
		localparam [31:0] OFS_W = `OFS_MISC_FIRST + gi;
		always @(posedge clk_i or posedge sys_rst_i) begin
			if (sys_rst_i)
				misc_r[gi] <= `REG_RESET;
			else if (reg_wr_i && sel(reg_page_i, reg_addr_i, OFS_W[7:0]))
				misc_r[gi] <= reg_wdata_i;
		end
	end
endgenerate

////////////////////////////////////////////////////////////////////////
always @(posedge clk_i or posedge sys_rst_i) begin
	if (sys_rst_i) begin
		reg_rdata_o  <= `REG_RESET;
		rx_cnt_ptr_o <= `REG_RESET;
		rx_adr_ptr_o <= `REG_RESET;
		tx_cnt_ptr_o <= `REG_RESET;
		tx_adr_ptr_o <= `REG_RESET;
		vec_base_r   <= 5'h00;
		ev_r         <= `EV_RX_ERROR;
		irq_vector_o <= `REG_RESET;
		match_char_r <= `REG_RESET;
		mask_r       <= `REG_RESET;
		flags_r      <= `REG_RESET;
		pri_r        <= `REG_RESET;
		rx_data_o    <= `REG_RESET;
		tx_data_o    <= `REG_RESET;
		tx_load_o    <= 1'b0;
		rx_full_r    <= 1'b0;
		rx_skip_r    <= 1'b0;
		tx_run_r     <= 1'b0;
		tx_want_r    <= 1'b0;
		dma_rx_req_o <= 1'b0;
		dma_tx_req_o <= 1'b0;
		irq_o        <= 1'b0;
	end else begin
		if (reg_rd_i)
			reg_rdata_o <= rdata_nxt;
		if (wr_rcp)
			rx_cnt_ptr_o <= reg_wdata_i;
		if (wr_rap)
			rx_adr_ptr_o <= reg_wdata_i;
		if (wr_tcp)
			tx_cnt_ptr_o <= reg_wdata_i;
		if (wr_tap)
			tx_adr_ptr_o <= reg_wdata_i;
		if (wr_vec)
			vec_base_r <= reg_wdata_i[7:3];
		if (wr_mch)
			match_char_r <= reg_wdata_i;
		mask_r  <= mask_nxt;
		flags_r <= flags_nxt;
		pri_r   <= pri_nxt;
		ev_r    <= ev_nxt;
		// Code taken from the same next value as irq_o, so the core
		// never reads the previous source beside a fresh request
		irq_vector_o <= {vec_base_r, ev_nxt, 1'b0};

		// Receive holding: overrun still overwrites, old byte lost
		// Full flag clears on a core read or on the controller's take
		if (rx_char_i)
			rx_data_o <= rx_data_i;
		if (rx_char_i)
			rx_full_r <= 1'b1;
		else if (rd_rxh | dma_rx_ack_i)
			rx_full_r <= 1'b0;
		if (skip_char)
			rx_skip_r <= 1'b1;
		else if (rx_char_i | rd_rxh)
			rx_skip_r <= 1'b0;

		// Receive channel request
		if (rx_raise)
			dma_rx_req_o <= 1'b1;
		else if (dma_rx_ack_i)
			dma_rx_req_o <= 1'b0;

		// Transmit holding: core write or DMA delivery
		// The arming byte goes out unpaced; later bytes each wait
		// for one selected empty event
		tx_load_o <= wr_txh | (dma_tx_ack_i & dma_tx_req_o);
		if (wr_txh)
			tx_data_o <= reg_wdata_i;
		else if (dma_tx_ack_i & dma_tx_req_o)
			tx_data_o <= dma_tx_data_i;
		if (wr_txh & tx_dma_en)
			tx_run_r <= 1'b1;
		else if (tx_done | ~tx_dma_en)
			tx_run_r <= 1'b0;
		if (tx_evt & tx_run_r & tx_dma_en & ~tx_done)
			tx_want_r <= 1'b1;
		else if (tx_raise | ~tx_run_r)
			tx_want_r <= 1'b0;

		// Transmit channel request
		if (tx_raise)
			dma_tx_req_o <= 1'b1;
		else if (dma_tx_ack_i)
			dma_tx_req_o <= 1'b0;

		// Interrupt yields while a DMA request is waiting or about
		// to be raised, so the core is not called away mid-transfer
		irq_o <= src_any & ~dma_rx_req_o & ~dma_tx_req_o
			& ~rx_raise & ~tx_raise;
	end
end

endmodule
`default_nettype wire

// >>> tb/serial_irq_dma_chk.sv
/*
 Port checker of the serial interrupt and DMA request logic.
 Assumes binding onto the design top with its page parameter.
*/
`timescale 1ns/100ps
`default_nettype none
module serial_irq_dma_chk #(
	parameter [7:0] INST_PAGE = 8'h18
) (
	// Watched ports
	input wire logic       clk_i,
	input wire logic       sys_rst_i,
	input wire logic [7:0] reg_page_i,
	input wire logic [7:0] reg_addr_i,
	input wire logic       reg_rd_i,
	input wire logic [7:0] reg_rdata_o,
	input wire logic       rx_char_i,
	input wire logic [7:0] rx_data_i,
	input wire logic [7:0] rx_data_o,
	input wire logic       tx_load_o,
	input wire logic [7:0] tx_data_o,
	input wire logic       dma_rx_ack_i,
	input wire logic       dma_tx_ack_i,
	input wire logic [7:0] dma_tx_data_i,
	input wire logic       dma_rx_req_o,
	input wire logic       dma_tx_req_o,
	input wire logic       irq_o,
	input wire logic [7:0] irq_vector_o
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (sys_rst_i);
	chk_rx_held: assert property (dma_rx_req_o && !dma_rx_ack_i |=> dma_rx_req_o)
		else $error("rx request dropped unserved");
	chk_tx_held: assert property (dma_tx_req_o && !dma_tx_ack_i |=> dma_tx_req_o)
		else $error("tx request dropped unserved");
	chk_rx_ends: assert property (dma_rx_ack_i && dma_rx_req_o |=> !dma_rx_req_o)
		else $error("rx request kept after ack");
	chk_irq_below: assert property (dma_rx_req_o || dma_tx_req_o |-> !irq_o)
		else $error("irq beside dma request");
	chk_rx_first: assert property ($rose(dma_tx_req_o) |-> !$rose(dma_rx_req_o))
		else $error("both requests raised together");
	chk_tx_byte: assert property (dma_tx_ack_i && dma_tx_req_o |=>
		tx_load_o && tx_data_o == $past(dma_tx_data_i))
		else $error("tx byte not loaded from dma");
	chk_rx_capture: assert property (rx_char_i |=> rx_data_o == $past(rx_data_i))
		else $error("rx byte not captured");
	chk_vector_low: assert property (irq_vector_o[0] == 1'b0)
		else $error("vector bit 0 set");
	chk_hold_read: assert property (reg_rd_i && reg_page_i == INST_PAGE && reg_addr_i == 8'hF8
		&& !rx_char_i |=> reg_rdata_o == $past(rx_data_o))
		else $error("holding read wrong");
	chk_page_other: assert property (reg_rd_i && reg_page_i != INST_PAGE |=>
		reg_rdata_o == 8'h00)
		else $error("foreign page answered");
endmodule
bind serial_irq_dma serial_irq_dma_chk #(.INST_PAGE(INST_PAGE)) serial_irq_dma_chk_i (.clk_i,
	.sys_rst_i, .reg_page_i, .reg_addr_i, .reg_rd_i, .reg_rdata_o, .rx_char_i, .rx_data_i,
	.rx_data_o, .tx_load_o, .tx_data_o, .dma_rx_ack_i, .dma_tx_ack_i, .dma_tx_data_i,
	.dma_rx_req_o, .dma_tx_req_o, .irq_o, .irq_vector_o);
`default_nettype wire

// >>> tb/dma_ctrl_model.sv
/*
 DMA controller model for both serial channels, index 0 rx, 1 tx.
 Assumes level requests held until a one-cycle acknowledge.
*/
`timescale 1ns/100ps
`default_nettype none
module dma_ctrl_model (
	// Clock, reset, settings
	input  wire logic       clk_i,
	input  wire logic       sys_rst_i,
	input  wire logic [3:0] dly_i,
	input  wire logic [3:0] len_i,
	// Requests and answers
	input  wire logic [1:0] req_i,
	output var  logic [1:0] ack_o,
	output var  logic [1:0] last_o,
	output var  logic [7:0] data_o
);
	logic [3:0] wait_r [2];
	logic [3:0] nb_r   [2];
	always @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			ack_o <= 2'h0;
			last_o <= 2'h0;
			data_o <= 8'h5A;
			for (int c = 0; c < 2; c++) begin
				wait_r[c] <= 4'h0;
				nb_r[c] <= 4'h0;
			end
		end else begin
			// Idle data toggles, never a stale byte
			data_o <= ~data_o;
			for (int c = 0; c < 2; c++) begin
				ack_o[c] <= 1'b0;
				last_o[c] <= 1'b0;
				if (req_i[c] && !ack_o[c]) begin
					wait_r[c] <= wait_r[c] + 4'h1;
					if (wait_r[c] >= dly_i) begin
						ack_o[c] <= 1'b1;
						last_o[c] <= nb_r[c] == len_i - 4'h1;
						nb_r[c] <= (nb_r[c] == len_i - 4'h1) ? 4'h0 : nb_r[c] + 4'h1;
						wait_r[c] <= 4'h0;
						if (c == 1)
							data_o <= 8'hA0 + {4'h0, nb_r[c]};
					end
				end
			end
		end
	end
endmodule
`default_nettype wire

// >>> tb/serial_irq_dma_tb.sv
/*
 Testbench of the serial interrupt and DMA request logic.
 Assumes the bound checker and the DMA controller model.
*/
`timescale 1ns/100ps
`default_nettype none
module serial_irq_dma_tb;
	logic       clk_i, sys_rst_i, reg_wr_i, reg_rd_i, rx_char_i, rx_frame_err_i;
	logic       rx_parity_err_i, rx_char_match_i, rx_addr_match_i, rx_break_i;
	logic       tx_buf_empty_i, tx_shift_empty_i, tx_load_o, irq_o;
	logic [7:0] reg_page_i, reg_addr_i, reg_wdata_i, reg_rdata_o, rx_data_i, tx_data_o;
	logic [7:0] dma_tx_data_i, rx_data_o, irq_vector_o;
	logic [1:0] ack, last, req;
	logic [7:0] ptr [4];
	logic [3:0] sig;
	int         failures, n_compared;
	assign sig = {tx_load_o, req, irq_o};
	serial_irq_dma serial_irq_dma_i (.clk_i, .sys_rst_i, .reg_page_i, .reg_addr_i, .reg_wr_i,
		.reg_rd_i, .reg_wdata_i, .reg_rdata_o, .rx_char_i, .rx_data_i, .rx_frame_err_i,
		.rx_parity_err_i, .rx_char_match_i, .rx_addr_match_i, .rx_break_i, .tx_buf_empty_i,
		.tx_shift_empty_i, .tx_load_o, .tx_data_o, .dma_rx_ack_i(ack[0]),
		.dma_rx_last_i(last[0]), .dma_tx_ack_i(ack[1]), .dma_tx_last_i(last[1]),
		.dma_tx_data_i, .dma_rx_req_o(req[0]), .dma_tx_req_o(req[1]), .rx_data_o,
		.rx_cnt_ptr_o(ptr[0]), .rx_adr_ptr_o(ptr[1]), .tx_cnt_ptr_o(ptr[2]),
		.tx_adr_ptr_o(ptr[3]), .irq_o,
		.irq_vector_o);
	dma_ctrl_model dma_ctrl_model_i (.clk_i, .sys_rst_i, .dly_i(4'h2), .len_i(4'h2),
		.req_i(req), .ack_o(ack), .last_o(last), .data_o(dma_tx_data_i));
	////////////////////////////////////////
	task end_sim;
		$display("compared %0d failures %0d", n_compared, failures);
		if (failures == 0 && n_compared > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	task chk(input string what, input logic [7:0] exp, got);
		n_compared++;
		if (got !== exp) begin
			failures++;
			$display("mismatch %s expected %h seen %h", what, exp, got);
		end
	endtask
	task wr(input logic [7:0] a, d);
		@(negedge clk_i);
		reg_addr_i = a;
		reg_wdata_i = d;
		reg_wr_i = 1'b1;
		@(negedge clk_i);
		reg_wr_i = 1'b0;
	endtask
	task rd(input logic [7:0] p, a, exp);
		@(negedge clk_i);
		reg_page_i = p;
		reg_addr_i = a;
		reg_rd_i = 1'b1;
		@(negedge clk_i);
		reg_rd_i = 1'b0;
		reg_page_i = 8'h18;
		chk("register", exp, reg_rdata_o);
	endtask
	// Kinds: 0 char, 1 parity, 2 framing, 3 break, 4 shift empty, 5 buffer empty, 6 match
	task ev(input int k, input logic [7:0] d);
		@(negedge clk_i);
		rx_data_i = d;
		rx_char_i = k < 3 || k == 6;
		rx_char_match_i = k == 6;
		rx_parity_err_i = k == 1;
		rx_frame_err_i = k == 2;
		rx_break_i = k == 3;
		tx_shift_empty_i = k == 4;
		tx_buf_empty_i = k == 5;
		@(negedge clk_i);
		{rx_char_i, rx_parity_err_i, rx_frame_err_i, rx_break_i, rx_char_match_i} = 5'h00;
		{tx_shift_empty_i, tx_buf_empty_i} = 2'h0;
		rx_data_i = ~d;
	endtask
	// Bounded wait: 0 irq, 1 rx request, 2 tx request, 3 tx load
	task wait_for(input int w, input logic [7:0] exp);
		int i;
		i = 0;
		while (sig[w] !== 1'b1 && i < 16) begin
			@(negedge clk_i);
			i++;
		end
		chk("awaited event", 8'h01, {7'h00, sig[w]});
		if (w == 0)
			chk("vector", exp, irq_vector_o);
		if (w == 3)
			chk("tx byte", exp, tx_data_o);
	endtask
	////////////////////////////////////////
	task t_regs;
		for (int i = 0; i < 4; i++) begin
			wr(8'hF0 + i[7:0], 8'h3C + i[7:0]);
			rd(8'h18, 8'hF0 + i[7:0], 8'h3C + i[7:0]);
			chk("pointer out", 8'h3C + i[7:0], ptr[i]);
		end
		rd(8'h19, 8'hF0, 8'h00);
		wr(8'hF7, 8'hFF);
		rd(8'h18, 8'hF7, 8'h00);
		wr(8'hF8, 8'h5A);
		chk("tx byte", 8'h5A, tx_data_o);
		rd(8'h18, 8'hF8, 8'h00);
	endtask
	task t_irq;
		wr(8'hF4, 8'hA8);
		wr(8'hF6, 8'h17);
		for (int k = 0; k < 5; k++) begin
			ev(k, 8'h30 + k[7:0]);
			wait_for(0, 8'hA8 | (k == 0 ? 8'h04 : k < 3 ? 8'h00 : k == 3 ? 8'h02 : 8'h06));
			if (k < 3)
				rd(8'h18, 8'hF8, 8'h30 + k[7:0]);
			wr(8'hF7, 8'h00);
			repeat (3) @(negedge clk_i);
			chk("irq cleared", 8'h00, {7'h00, irq_o});
		end
	endtask
	task t_src_sel;
		wr(8'hF6, 8'h81);
		ev(4, 8'h00);
		repeat (4) @(negedge clk_i);
		chk("irq on shift empty", 8'h00, {7'h00, irq_o});
		ev(5, 8'h00);
		wait_for(0, 8'hAE);
		wr(8'hF7, 8'h00);
	endtask
	task t_rx_dma;
		wr(8'hF6, 8'h12);
		wr(8'hF9, 8'h80);
		ev(0, 8'h41);
		wait_for(1, 8'h00);
		repeat (4) @(negedge clk_i);
		chk("irq during dma", 8'h00, {7'h00, irq_o});
		ev(0, 8'h42);
		wait_for(0, 8'hAC);
		rd(8'h18, 8'hF6, 8'h52);
		rd(8'h18, 8'hF9, 8'h00);
		wr(8'hF6, 8'h12);
		wr(8'hF9, 8'h80);
		ev(2, 8'h43);
		wait_for(0, 8'hA8);
		chk("request on error", 8'h00, {7'h00, req[0]});
		wr(8'hF7, 8'h00);
		rd(8'h18, 8'hF8, 8'h43);
		ev(0, 8'h44);
		wait_for(1, 8'h00);
		repeat (8) @(negedge clk_i);
		wr(8'hF9, 8'h00);
		wr(8'hF7, 8'h00);
		wr(8'hF6, 8'h08);
		wr(8'hF9, 8'hA0);
		ev(6, 8'h45);
		wait_for(0, 8'hAA);
		chk("request on match", 8'h00, {7'h00, req[0]});
		rd(8'h18, 8'hF8, 8'h45);
		ev(0, 8'h46);
		wait_for(1, 8'h00);
		repeat (8) @(negedge clk_i);
		wr(8'hF9, 8'h00);
		wr(8'hF7, 8'h00);
	endtask
	task t_tx_dma;
		wr(8'hF6, 8'h01);
		wr(8'hF9, 8'h40);
		wr(8'hF8, 8'h55);
		wait_for(3, 8'h55);
		ev(4, 8'h00);
		wait_for(3, 8'hA0);
		ev(4, 8'h00);
		wait_for(3, 8'hA1);
		wait_for(0, 8'hAE);
		rd(8'h18, 8'hF6, 8'h21);
		rd(8'h18, 8'hF9, 8'h00);
		wr(8'hF2, 8'h3E);
		wr(8'hF3, 8'h3F);
		wr(8'hF7, 8'h00);
		wr(8'hF6, 8'h01);
		wr(8'hF9, 8'h40);
		wr(8'hF8, 8'h66);
		wait_for(3, 8'h66);
		ev(4, 8'h00);
		wait_for(3, 8'hA0);
		chk("irq in chained block", 8'h00, {7'h00, irq_o});
	endtask
	////////////////////////////////////////
	initial begin
		clk_i = 1'b0;
		forever #2.5 clk_i = ~clk_i;
	end
	// Run needs under a thousand cycles
	initial begin
		#40000;
		failures++;
		end_sim;
	end
	initial begin
		{reg_wr_i, reg_rd_i, rx_char_i, rx_frame_err_i, rx_parity_err_i} = 5'h00;
		{rx_char_match_i, rx_addr_match_i, rx_break_i, tx_buf_empty_i, tx_shift_empty_i} = 5'h00;
		{reg_addr_i, reg_wdata_i, rx_data_i} = 24'h000000;
		reg_page_i = 8'h18;
		sys_rst_i = 1'b1;
		repeat (20) @(negedge clk_i);
		sys_rst_i = 1'b0;
		t_regs;
		t_irq;
		t_src_sel;
		t_rx_dma;
		t_tx_dma;
		end_sim;
	end
endmodule
`default_nettype wire
